// ==== hw/status_report_pkg.sv ====
// Package with the input image layout, event codes and timing constants.
package status_report_pkg;

  // Word indices of the ten-word input image.
  localparam logic [3:0] WORD_MOTION_STATUS = 4'h0;
  localparam logic [3:0] WORD_DRIVE_STATUS = 4'h1;
  localparam logic [3:0] WORD_PROFILE_POS = 4'h2;
  localparam logic [3:0] WORD_ENCODER_POS = 4'h4;
  localparam logic [3:0] WORD_CAPTURED_POS = 4'h6;
  localparam logic [3:0] WORD_PEAK_CURRENT = 4'h8;
  localparam logic [3:0] WORD_VELOCITY = 4'h9;
  localparam int IMAGE_WORDS = 10;

  // Position window for enabling, in counts.
  localparam logic [31:0] ENABLE_POS_WINDOW = 32'h0000_1000;

  // Heartbeat half period.
  localparam int HEARTBEAT_MS = 500;
  localparam int CLOCK_MHZ = 250;
  localparam int HEARTBEAT_CYCLES = HEARTBEAT_MS * 1000 * CLOCK_MHZ;

  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;

  // One-cycle events reported by the motion engine.
  typedef struct packed {
    logic invalid_command;
    logic move_while_disabled;
    logic disable_in_motion;
    logic config_while_enabled;
    logic enable_attempt;
    logic preset_on_enable;
    logic estop_on;
    logic limit_in_move;
    logic jog_into_limit;
    logic home_opposite_limit;
    logic abs_encoder_fault_at_power;
    logic stall_stopped;
    logic move_done_ok;
    logic move_cmd_written;
    logic position_preset;
    logic reset_errors;
    logic homing_done_ok;
    logic follower_accepted;
    logic follower_ended;
    logic cmd_ack_set;
    logic cmd_bit_low;
    logic conn_restored;
  } motion_events_t;

  // Levels describing the present state of the drive.
  typedef struct packed {
    logic config_mode;
    logic internal_fault;
    logic config_invalid;
    logic decelerating;
    logic accelerating;
    logic in_motion;
    logic in_hold;
    logic turning_counterclockwise;
    logic turning_clockwise;
    logic power_stage_on;
    logic abs_encoder_error;
    logic torque_limit;
    logic jog_params_invalid;
    logic safe_off_discrepancy;
    logic driver_fault;
    logic safe_off_engaged;
    logic over_temperature;
    logic input_four_on;
    logic input_three_on;
    logic input_two_on;
    logic input_one_on;
  } drive_levels_t;

  // Raw motion quantities.
  typedef struct packed {
    logic [31:0] profile_position;
    logic [31:0] encoder_position;
    logic [31:0] captured_encoder_position;
    logic [15:0] peak_current_x100;
    logic [15:0] motor_velocity;
    logic [31:0] max_position_error;
  } motion_values_t;

endpackage

// ==== hw/servo_status_report.sv ====
// Command-mode network input image builder for the servo indexer.
// Summary of operation
// - Ten words: two status, profile, encoder, captured, current x100, velocity.
// - Current and velocity reported negative while position decreases.
// - Motion status bit 15 is one in configuration mode.
// - Motion status bit 14 is one while no internal fault exists.
// - Motion status bit 13 is one when no valid configuration held.
// - Command error on bad command, move disabled, disable in motion.
// - Command error on config entry enabled, or enable outside window.
// - Command and input errors hold until a reset-errors command.
// - Input error on emergency stop or limit in non-homing move.
// - Input error on jog into active limit or opposite limit homing.
// - Position invalid on encoder power-up error or enable window miss.
// - Position invalid on stall-stop overrun; bits 9 and 8 read zero.
// - Move complete set only by absolute, relative or registration moves.
// - Move complete cleared by next move, preset or reset errors.
// - Bit 6 while decelerating, bit 5 while accelerating.
// - Bit 4 set only after homing completes successfully.
// - Stopped set whenever motor still in normal moves.
// - Stopped held clear from follower acceptance until follower ends.
// - Bit 2 hold state, bit 1 counterclockwise, bit 0 clockwise.
// - Drive status bit 15 mirrors power stage enabled.
// - Drive status bit 14 set when following error exceeds limit.
// - Drive status bits 13 to 0 hold ack, encoder, heartbeat and rest.
// - Heartbeat toggles every 500 ms in command mode.
// - Reset errors also clears stall, jog change and connection lost.
`timescale 1ns/100ps
`default_nettype none

module servo_status_report
  import status_report_pkg::*;
#(
  parameter int HEARTBEAT_COUNT = HEARTBEAT_CYCLES
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Drive state from the motion engine.
  input wire motion_events_t events_i,
  input wire drive_levels_t levels_i,
  input wire motion_values_t values_i,
  // Network image read port.
  input wire logic update_i,
  input wire logic [3:0] word_sel_i,
  output logic [15:0] word_o,
  output logic [15:0] motion_status_o,
  output logic [15:0] drive_status_o
);

  // Absolute difference of two signed positions.
  function automatic logic [31:0] abs_diff(input logic [31:0] a,
                                           input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    abs_diff = d[31] ? (32'h0 - d) : d;
  endfunction

  // Negate a magnitude when the position is falling.
  function automatic logic [15:0] signed_mag(input logic [15:0] m,
                                             input logic neg);
    signed_mag = neg ? (16'h0 - m) : m;
  endfunction

  logic cmd_err_reg;
  logic in_err_reg;
  logic pos_inv_reg;
  logic move_cmp_reg;
  logic homed_reg;
  logic follower_reg;
  logic stall_reg;
  logic jog_chg_reg;
  logic conn_lost_reg;
  logic cmd_ack_reg;
  logic heartbeat_reg;
  logic [31:0] hb_count_reg;
  logic [31:0] last_pos_reg;
  logic falling_reg;
  logic falling_now;
  logic [15:0] image_reg [IMAGE_WORDS];
  logic [15:0] word_reg;
  logic window_miss;
  logic follow_err;
  logic [15:0] motion_next;
  logic [15:0] drive_next;

  // The window test is a magnitude, so a wrap in either direction counts.
  assign window_miss = abs_diff(values_i.profile_position,
                                values_i.encoder_position) > ENABLE_POS_WINDOW;
  assign follow_err = abs_diff(values_i.profile_position,
                               values_i.encoder_position) >
                      values_i.max_position_error;

  // Sticky error flags; a setting event beats a reset in the same cycle.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cmd_err_reg <= 1'b0;
      in_err_reg <= 1'b0;
    end else begin
      if (events_i.invalid_command || events_i.move_while_disabled ||
          events_i.disable_in_motion) begin
        cmd_err_reg <= 1'b1;
      end else if (events_i.config_while_enabled ||
                   (events_i.enable_attempt && window_miss &&
                    !events_i.preset_on_enable)) begin
        cmd_err_reg <= 1'b1;
      end else if (events_i.reset_errors) begin
        cmd_err_reg <= 1'b0;
      end
      if (events_i.estop_on || events_i.limit_in_move) begin
        in_err_reg <= 1'b1;
      end else if (events_i.jog_into_limit ||
                   events_i.home_opposite_limit) begin
        in_err_reg <= 1'b1;
      end else if (events_i.reset_errors) begin
        in_err_reg <= 1'b0;
      end
    end
  end

  // Position invalid is not cleared by reset errors, only by a preset.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pos_inv_reg <= 1'b0;
    end else if (events_i.abs_encoder_fault_at_power ||
                 (events_i.enable_attempt && window_miss &&
                  !events_i.preset_on_enable)) begin
      pos_inv_reg <= 1'b1;
    end else if (events_i.stall_stopped && follow_err) begin
      pos_inv_reg <= 1'b1;
    end else if (events_i.position_preset) begin
      pos_inv_reg <= 1'b0;
    end
  end

  // Move completion and homing results.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      move_cmp_reg <= 1'b0;
      homed_reg <= 1'b0;
    end else begin
      if (events_i.move_done_ok) begin
        move_cmp_reg <= 1'b1;
      end else if (events_i.move_cmd_written || events_i.position_preset ||
                   events_i.reset_errors) begin
        move_cmp_reg <= 1'b0;
      end
      if (events_i.homing_done_ok) begin
        homed_reg <= 1'b1;
      end else if (events_i.move_cmd_written || events_i.position_preset) begin
        homed_reg <= 1'b0;
      end
    end
  end

  // Follower state keeps the stopped flag low regardless of motion.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      follower_reg <= 1'b0;
    end else if (events_i.follower_accepted) begin
      follower_reg <= 1'b1;
    end else if (events_i.follower_ended) begin
      follower_reg <= 1'b0;
    end
  end

  // Latched drive status flags.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      stall_reg <= 1'b0;
      jog_chg_reg <= 1'b0;
      conn_lost_reg <= 1'b0;
    end else begin
      if (follow_err) begin
        stall_reg <= 1'b1;
      end else if (events_i.reset_errors) begin
        stall_reg <= 1'b0;
      end
      if (levels_i.jog_params_invalid) begin
        jog_chg_reg <= 1'b1;
      end else if (events_i.reset_errors || !levels_i.in_motion) begin
        jog_chg_reg <= 1'b0;
      end
      if (events_i.conn_restored) begin
        conn_lost_reg <= 1'b1;
      end else if (events_i.reset_errors) begin
        conn_lost_reg <= 1'b0;
      end
    end
  end

  // Acknowledge stays until the host drops its command bit.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cmd_ack_reg <= 1'b0;
    end else if (events_i.cmd_ack_set) begin
      cmd_ack_reg <= 1'b1;
    end else if (events_i.cmd_bit_low) begin
      cmd_ack_reg <= 1'b0;
    end
  end

  // Heartbeat runs only in command mode; in configuration mode the host reads the bit as zero.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      hb_count_reg <= 32'h0;
      heartbeat_reg <= 1'b0;
    end else if (!levels_i.config_mode) begin
      if (hb_count_reg >= 32'(HEARTBEAT_COUNT - 1)) begin
        hb_count_reg <= 32'h0;
        heartbeat_reg <= !heartbeat_reg;
      end else begin
        hb_count_reg <= hb_count_reg + 32'h1;
      end
    end
  end

  // Direction at this update; an unchanged position keeps the last one.
  always_comb begin
    falling_now = falling_reg;
    if (values_i.encoder_position != last_pos_reg) begin
      falling_now = $signed(values_i.encoder_position - last_pos_reg) < 0;
    end
  end

  // The snapshot uses the direction of this very update, not the last one.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      last_pos_reg <= POS_RESET;
      falling_reg <= 1'b0;
    end else if (update_i) begin
      last_pos_reg <= values_i.encoder_position;
      falling_reg <= falling_now;
    end
  end

  always_comb begin
    motion_next = STATUS_RESET;
    motion_next[15] = levels_i.config_mode;
    motion_next[14] = !levels_i.internal_fault;
    motion_next[13] = levels_i.config_invalid;
    motion_next[12] = cmd_err_reg;
    motion_next[11] = in_err_reg;
    motion_next[10] = pos_inv_reg;
    motion_next[9:8] = 2'b00;
    motion_next[7] = move_cmp_reg;
    motion_next[6] = levels_i.decelerating;
    motion_next[5] = levels_i.accelerating;
    motion_next[4] = homed_reg;
    motion_next[3] = !levels_i.in_motion && !follower_reg;
    motion_next[2] = levels_i.in_hold;
    motion_next[1] = levels_i.turning_counterclockwise;
    motion_next[0] = levels_i.turning_clockwise;
  end

  always_comb begin
    drive_next = STATUS_RESET;
    drive_next[15] = levels_i.power_stage_on;
    drive_next[14] = stall_reg;
    drive_next[13] = cmd_ack_reg;
    drive_next[12] = levels_i.abs_encoder_error;
    drive_next[11] = heartbeat_reg && !levels_i.config_mode;
    drive_next[10] = levels_i.torque_limit;
    drive_next[9] = jog_chg_reg;
    drive_next[8] = levels_i.safe_off_discrepancy;
    drive_next[7] = levels_i.driver_fault;
    drive_next[6] = conn_lost_reg;
    drive_next[5] = levels_i.safe_off_engaged;
    drive_next[4] = levels_i.over_temperature;
    drive_next[3] = levels_i.input_four_on;
    drive_next[2] = levels_i.input_three_on;
    drive_next[1] = levels_i.input_two_on;
    drive_next[0] = levels_i.input_one_on;
  end

  // Snapshot the whole image at once so a read never mixes two updates.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < IMAGE_WORDS; i++) begin
        image_reg[i] <= STATUS_RESET;
      end
    end else if (update_i) begin
      image_reg[WORD_MOTION_STATUS] <= motion_next;
      image_reg[WORD_DRIVE_STATUS] <= drive_next;
      image_reg[WORD_PROFILE_POS] <= values_i.profile_position[15:0];
      image_reg[WORD_PROFILE_POS + 4'h1] <= values_i.profile_position[31:16];
      image_reg[WORD_ENCODER_POS] <= values_i.encoder_position[15:0];
      image_reg[WORD_ENCODER_POS + 4'h1] <= values_i.encoder_position[31:16];
      image_reg[WORD_CAPTURED_POS] <=
        values_i.captured_encoder_position[15:0];
      image_reg[WORD_CAPTURED_POS + 4'h1] <=
        values_i.captured_encoder_position[31:16];
      image_reg[WORD_PEAK_CURRENT] <=
        signed_mag(values_i.peak_current_x100, falling_now);
      image_reg[WORD_VELOCITY] <=
        signed_mag(values_i.motor_velocity, falling_now);
    end
  end

  // Read port; words beyond the image read as zero.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      word_reg <= STATUS_RESET;
    end else if (word_sel_i < 4'(IMAGE_WORDS)) begin
      word_reg <= image_reg[word_sel_i];
    end else begin
      word_reg <= STATUS_RESET;
    end
  end

  assign word_o = word_reg;
  assign motion_status_o = image_reg[WORD_MOTION_STATUS];
  assign drive_status_o = image_reg[WORD_DRIVE_STATUS];

endmodule // servo_status_report

`default_nettype wire

// ==== dv/servo_status_report_properties.sv ====
// Concurrent checks on the ports of the input image builder.
`timescale 1ns/100ps
`default_nettype none
module servo_status_report_properties
  import status_report_pkg::*;
#(
  parameter int HEARTBEAT_COUNT = HEARTBEAT_CYCLES
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Observed ports.
  input wire motion_events_t events_i,
  input wire drive_levels_t levels_i,
  input wire motion_values_t values_i,
  input wire logic update_i,
  input wire logic [3:0] word_sel_i,
  input wire logic [15:0] word_o,
  input wire logic [15:0] motion_status_o,
  input wire logic [15:0] drive_status_o
);
  default clocking dc @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_reserved_zero: assert property (motion_status_o[9:8] == 2'b00)
    else $error("reserved status bits not zero");
  a_mode_flag: assert property (update_i |=>
    motion_status_o[15] == $past(levels_i.config_mode))
    else $error("mode flag wrong");
  a_fault_flag: assert property (update_i |=>
    motion_status_o[14] != $past(levels_i.internal_fault))
    else $error("ok flag wrong");
  a_ramp_flags: assert property (update_i |=>
    motion_status_o[6] == $past(levels_i.decelerating) &&
    motion_status_o[5] == $past(levels_i.accelerating))
    else $error("ramp flags wrong");
  a_power_flag: assert property (update_i |=>
    drive_status_o[15] == $past(levels_i.power_stage_on))
    else $error("power stage flag wrong");
  a_beat_config: assert property (update_i && levels_i.config_mode |=>
    !drive_status_o[11])
    else $error("heartbeat in configuration mode");
  a_refused_word: assert property (word_sel_i > 4'h9 |=> word_o == 16'h0000)
    else $error("out of range word not zero");
  a_word_mirror: assert property (!update_i && word_sel_i == 4'h1 |=>
    word_o == drive_status_o)
    else $error("word one differs from drive status");
  a_image_stands: assert property (!update_i |=>
    $stable(motion_status_o) && $stable(drive_status_o))
    else $error("image changed without update");
  a_done_flag: assert property (events_i.move_done_ok ##1 update_i |=>
    motion_status_o[7])
    else $error("move complete missing");
  a_cmd_error: assert property (events_i.invalid_command ##1 update_i |=>
    motion_status_o[12])
    else $error("command error missing");
endmodule // servo_status_report_properties
bind servo_status_report servo_status_report_properties #(
  .HEARTBEAT_COUNT(HEARTBEAT_COUNT)
) props (
  .mclk_i(mclk_i),
  .rst_b_i(rst_b_i),
  .events_i(events_i),
  .levels_i(levels_i),
  .values_i(values_i),
  .update_i(update_i),
  .word_sel_i(word_sel_i),
  .word_o(word_o),
  .motion_status_o(motion_status_o),
  .drive_status_o(drive_status_o)
);
`default_nettype wire

// ==== dv/host_reader.sv ====
// Host controller model that snapshots and reads the input image.
`timescale 1ns/100ps
`default_nettype none
module host_reader (
  // Clock and request.
  input wire logic mclk_i,
  input wire logic start_i,
  input wire logic [15:0] word_i,
  // Image read port.
  output logic update_o,
  output logic [3:0] sel_o,
  output logic got_o,
  output logic [15:0] got_word_o
);
  // Indices above nine are read too, so the refused range is exercised.
  initial begin
    update_o = 1'b0;
    sel_o = 4'hF;
    got_o = 1'b0;
    got_word_o = 16'h0000;
    forever begin
      @(posedge mclk_i);
      if (start_i) begin
        #1 update_o = 1'b1;
        for (int i = 0; i < 16; i++) begin
          @(posedge mclk_i);
          #1 update_o = 1'b0;
          got_o = (i > 0);
          got_word_o = word_i;
          sel_o = i[3:0];
        end
        @(posedge mclk_i);
        #1 got_o = 1'b1;
        got_word_o = word_i;
        @(posedge mclk_i);
        #1 got_o = 1'b0;
      end
    end
  end
endmodule // host_reader
`default_nettype wire

// ==== dv/servo_status_report_tb.sv ====
// Self-checking bench of the command-mode input image builder.
`timescale 1ns/100ps
`default_nettype none
module servo_status_report_tb;
  import status_report_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  motion_events_t ev = '0;
  drive_levels_t lv = '0;
  motion_values_t va = '0;
  logic start = 1'b0;
  logic upd, got;
  logic [3:0] sel;
  logic [15:0] word, got_word;
  logic [20:0] exp_q[$];
  logic [20:0] e;
  logic [31:0] rng = 32'h3FB6BBD6;
  logic [31:0] last_enc = 32'h0000_0000;
  int err_count = 0;
  int cmp_count = 0;
  logic cmd_err, in_err, pos_inv, mv_cmp, homed, follow, stall, ack, conn, neg;
  always #2 mclk_i = ~mclk_i;
  servo_status_report #(.HEARTBEAT_COUNT(8)) dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .events_i(ev), .levels_i(lv),
    .values_i(va), .update_i(upd), .word_sel_i(sel), .word_o(word),
    .motion_status_o(), .drive_status_o());
  host_reader host (.mclk_i(mclk_i), .start_i(start), .word_i(word),
    .update_o(upd), .sel_o(sel), .got_o(got), .got_word_o(got_word));
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic check(string what, logic [15:0] ex, logic [15:0] seen);
    cmp_count++;
    if (seen !== ex) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, ex, seen);
    end
  endtask
  // The heartbeat phase is free running, so it is masked in command mode.
  always @(posedge mclk_i) begin
    if (got === 1'b1) begin
      e = exp_q.pop_front();
      if (e[20]) e[11] = got_word[11];
      check("image word", e[15:0], got_word);
    end
  end
  task automatic shuffle();
    logic [31:0] r;
    r = rnd();
    lv = r[20:0];
    lv.jog_params_invalid = 1'b0;
    va.profile_position = rnd() & 32'h00FF_FFFF;
    va.encoder_position = rnd() & 32'h00FF_FFFF;
    va.captured_encoder_position = rnd();
    r = rnd();
    va.peak_current_x100 = r[15:0];
    va.motor_velocity = r[31:16];
  endtask
  task automatic step(motion_events_t x);
    logic [31:0] d;
    logic miss;
    logic [15:0] w[16];
    d = va.profile_position - va.encoder_position;
    if (d[31]) d = -d;
    miss = x.enable_attempt && !x.preset_on_enable && d > ENABLE_POS_WINDOW;
    stall = (stall && !x.reset_errors) || d > va.max_position_error;
    cmd_err = (cmd_err && !x.reset_errors) || |x[21:18] || miss;
    in_err = (in_err && !x.reset_errors) || |x[15:12];
    pos_inv = (pos_inv && !x.position_preset) || x[11] || miss
      || (x.stall_stopped && d > va.max_position_error);
    mv_cmp = (mv_cmp && !(|x[8:6])) || x.move_done_ok;
    homed = (homed && !(|x[8:7])) || x.homing_done_ok;
    follow = (follow && !x.follower_ended) || x.follower_accepted;
    ack = (ack && !x.cmd_bit_low) || x.cmd_ack_set;
    conn = (conn && !x.reset_errors) || x.conn_restored;
    if ($signed(va.encoder_position) < $signed(last_enc)) neg = 1'b1;
    else if (va.encoder_position != last_enc) neg = 1'b0;
    last_enc = va.encoder_position;
    w = '{default: 16'h0000};
    w[0] = {lv[20], !lv.internal_fault, lv[18], cmd_err, in_err, pos_inv,
      2'b00, mv_cmp, lv[17:16], homed, !lv.in_motion && !follow, lv[14:12]};
    w[1] = {lv.power_stage_on, stall, ack, lv.abs_encoder_error, 1'b0,
      lv.torque_limit, 1'b0, lv[7:6], conn, lv[5:0]};
    {w[3], w[2]} = va.profile_position;
    {w[5], w[4]} = va.encoder_position;
    {w[7], w[6]} = va.captured_encoder_position;
    w[8] = neg ? -va.peak_current_x100 : va.peak_current_x100;
    w[9] = neg ? -va.motor_velocity : va.motor_velocity;
    for (int i = 0; i < 16; i++) begin
      exp_q.push_back({i == 1 && !lv.config_mode, i[3:0], w[i]});
    end
    @(posedge mclk_i);
    #1 ev = x;
    start = 1'b1;
    @(posedge mclk_i);
    #1 ev = '0;
    start = 1'b0;
    for (int k = 0; k < 40 && exp_q.size() > 0; k++) #4;
    check("pending words", 16'h0000, 16'(exp_q.size()));
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // A hung frame would otherwise stall the run forever.
  initial begin
    #20000;
    err_count++;
    summarize();
  end
  initial begin
    logic [31:0] r;
    {cmd_err, in_err, pos_inv, mv_cmp, homed, follow, stall, ack, conn} = '0;
    neg = 1'b0;
    va.max_position_error = 32'h7FFF_FFFF;
    repeat (4) @(posedge mclk_i);
    #1 rst_b_i = 1'b1;
    for (int i = 21; i >= 0; i--) begin
      shuffle();
      step(22'h1 << i);
    end
    va.max_position_error = 32'h0000_0000;
    step(22'h00_0400);
    va.max_position_error = 32'h7FFF_FFFF;
    step(22'h00_0040);
    repeat (12) begin
      shuffle();
      r = rnd();
      step(r[21:0]);
    end
    summarize();
  end
endmodule // servo_status_report_tb
`default_nettype wire
